// ### core/pcea_gen.sv
// pc-relative, absolute and immediate operand location generator
module pcea_gen (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // decode request
  input wire logic req_i,
  input wire logic [2:0] mode_i,
  input wire logic [2:0] reg_i,
  input wire logic write_i,
  input wire pcea_pkg::pcea_imm_t imm_type_i,
  input wire logic [31:0] ext_pc_i,
  input wire logic [15:0] ext_w0_i,
  input wire logic [15:0] ext_w1_i,
  input wire logic [15:0] ext_w2_i,
  input wire logic [15:0] ext_w3_i,
  input wire logic [15:0] ext_w4_i,
  input wire logic [15:0] ext_w5_i,
  input wire logic [31:0] index_register_i,
  // intermediate long-word fetch
  output logic fetch_req_o,
  output logic [31:0] fetch_addr_o,
  input wire logic fetch_ack_i,
  input wire logic [31:0] fetch_data_i,
  // result
  output logic busy_o,
  output logic done_o,
  output logic [31:0] operand_location_o,
  output logic loc_valid_o,
  output logic program_space_o,
  output logic data_reg_indirect_o,
  output logic [95:0] imm_data_o,
  output logic imm_valid_o,
  output logic [2:0] ext_words_o,
  output logic write_refused_o,
  output logic bad_mode_o
);
  import pcea_pkg::*;

  pcea_state_t state_q, state_d;
  logic [31:0] loc_q, loc_d;
  logic [31:0] outer_q, outer_d;
  logic [31:0] post_q, post_d;
  logic [95:0] imm_q, imm_d;
  logic [2:0] words_q, words_d;
  logic lv_q, lv_d, iv_q, iv_d, ps_q, ps_d, dri_q, dri_d;
  logic wr_q, wr_d, bad_q, bad_d, done_q, done_d;

  pcea_idx_if idx ();
  assign idx.ext_word = ext_w0_i;
  assign idx.reg_value = index_register_i;
  pcea_index u_index (.idx(idx));

  // mode decode
  wire is_ext = (mode_i == MODE_EXT);
  wire m_abs_w = is_ext && (reg_i == REG_ABS_W);
  wire m_abs_l = is_ext && (reg_i == REG_ABS_L);
  wire m_disp = is_ext && (reg_i == REG_PC_DISP);
  wire m_idx = is_ext && (reg_i == REG_PC_IDX);
  wire m_imm = is_ext && (reg_i == REG_IMM);
  wire m_pc = m_disp || m_idx;
  wire full_fmt = ext_w0_i[XW_FULL];

  // full extension word fields
  wire base_sup = ext_w0_i[XW_BS];
  wire idx_sup = ext_w0_i[XW_IS];
  wire [1:0] base_sz = ext_w0_i[XW_BASE_HI:XW_BASE_LO];
  wire [2:0] iis = ext_w0_i[XW_IIS_HI:XW_IIS_LO];
  wire mem_ind = (iis != 3'h0);
  wire post_idx = iis[2];
  wire [1:0] outer_sz = iis[1:0];
  wire bad_iis = (iis == 3'h4) || (idx_sup && iis[2]);

  // the pc is the address of the first extension word in every form
  wire [31:0] pc_val = ext_pc_i;
  wire [31:0] base_pc = base_sup ? 32'h0000_0000 : pc_val;
  wire [31:0] index_term = idx_sup ? 32'h0000_0000 : idx.scaled;

  // base displacement starts at the second word
  wire [31:0] base_disp = disp(base_sz, ext_w1_i, ext_w2_i);
  wire [15:0] outer_w0 = (base_sz == DSZ_LONG) ? ext_w3_i
                       : (base_sz == DSZ_WORD) ? ext_w2_i : ext_w1_i;
  wire [15:0] outer_w1 = (base_sz == DSZ_LONG) ? ext_w4_i
                       : (base_sz == DSZ_WORD) ? ext_w3_i : ext_w2_i;
  wire [31:0] outer_disp = disp(outer_sz, outer_w0,
                                outer_w1);
  wire [2:0] base_words = (base_sz == DSZ_LONG) ? 3'h2
                        : (base_sz == DSZ_WORD) ? 3'h1 : 3'h0;
  wire [2:0] outer_words = (outer_sz == DSZ_LONG) ? 3'h2
                         : (outer_sz == DSZ_WORD) ? 3'h1 : 3'h0;
  wire [2:0] full_words = 3'(3'h1 + base_words
                             + (mem_ind ? outer_words : 3'h0));

  // address sums, all modulo 2^32
  wire [31:0] sum_disp = pc_val + sx16(ext_w0_i);
  wire [31:0] sum_brief = pc_val + sx8(ext_w0_i[7:0])
                        + idx.scaled;
  wire [31:0] sum_full = base_pc + base_disp + index_term;
  wire [31:0] sum_pre = base_pc + base_disp + index_term;
  wire [31:0] sum_post = base_pc + base_disp;

  // immediate extraction
  wire [95:0] imm_words_cat = {ext_w0_i, ext_w1_i, ext_w2_i,
                               ext_w3_i, ext_w4_i, ext_w5_i};
  logic [95:0] imm_val;
  always_comb begin
    case (imm_type_i)
      IMM_BYTE: imm_val = {88'h0, ext_w0_i[7:0]};
      IMM_WORD: imm_val = {80'h0, ext_w0_i};
      IMM_LONG, IMM_SGL: imm_val = {64'h0, ext_w0_i, ext_w1_i};
      IMM_DBL: imm_val = {32'h0, imm_words_cat[95:32]};
      default: imm_val = imm_words_cat;
    endcase
  end

  always_comb begin
    state_d = state_q;
    loc_d = loc_q;
    outer_d = outer_q;
    post_d = post_q;
    imm_d = imm_q;
    words_d = words_q;
    lv_d = lv_q;
    iv_d = iv_q;
    ps_d = ps_q;
    dri_d = dri_q;
    wr_d = wr_q;
    bad_d = bad_q;
    done_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (req_i) begin
          lv_d = 1'b0;
          iv_d = 1'b0;
          ps_d = 1'b0;
          dri_d = 1'b0;
          wr_d = 1'b0;
          bad_d = 1'b0;
          words_d = 3'h0;
          state_d = ST_CALC;
        end
      end
      ST_CALC: begin
        state_d = ST_DONE;
        if (!is_ext || (m_pc && write_i) || (m_imm && write_i)) begin
          // pc-relative and immediate operands cannot be written
          wr_d = m_pc || m_imm;
          bad_d = !is_ext;
        end else if (m_abs_w) begin
          loc_d = sx16(ext_w0_i);
          lv_d = 1'b1;
          words_d = 3'h1;
        end else if (m_abs_l) begin
          loc_d = {ext_w0_i, ext_w1_i};
          lv_d = 1'b1;
          words_d = 3'h2;
        end else if (m_disp) begin
          loc_d = sum_disp;
          lv_d = 1'b1;
          ps_d = 1'b1;
          words_d = 3'h1;
        end else if (m_idx && !full_fmt) begin
          loc_d = sum_brief;
          lv_d = 1'b1;
          ps_d = 1'b1;
          words_d = 3'h1;
        end else if (m_idx && bad_iis) begin
          bad_d = 1'b1;
        end else if (m_idx && !mem_ind) begin
          loc_d = sum_full;
          lv_d = 1'b1;
          ps_d = 1'b1;
          // no pc, no base displacement, data index: (Dn) in program space
          dri_d = base_sup && !idx_sup && idx.is_data
                  && (base_sz == DSZ_NULL);
          words_d = full_words;
        end else if (m_idx) begin
          loc_d = post_idx ? sum_post : sum_pre;
          post_d = post_idx ? index_term : 32'h0000_0000;
          outer_d = outer_disp;
          ps_d = 1'b1;
          words_d = full_words;
          state_d = ST_FETCH;
        end else if (m_imm) begin
          imm_d = imm_val;
          iv_d = 1'b1;
          words_d = imm_words(imm_type_i);
        end else begin
          bad_d = 1'b1;
        end
      end
      ST_FETCH: begin
        // fetch stalls until memory answers
        if (fetch_ack_i) begin
          loc_d = fetch_data_i + post_q + outer_q;
          lv_d = 1'b1;
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      done_q <= done_d;
    end
  end

  // the fetch address is this register, so it holds through a fetch stall
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      loc_q <= ADDR_RST;
    end else begin
      loc_q <= loc_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      outer_q <= ADDR_RST;
      post_q <= ADDR_RST;
    end else begin
      outer_q <= outer_d;
      post_q <= post_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      imm_q <= IMM_RST;
    end else begin
      imm_q <= imm_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      words_q <= 3'h0;
    end else begin
      words_q <= words_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      lv_q <= 1'b0;
      iv_q <= 1'b0;
    end else begin
      lv_q <= lv_d;
      iv_q <= iv_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ps_q <= 1'b0;
      dri_q <= 1'b0;
    end else begin
      ps_q <= ps_d;
      dri_q <= dri_d;
    end
  end

  // result flags are cleared by the next-state logic on each accepted request
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wr_q <= 1'b0;
      bad_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      bad_q <= bad_d;
    end
  end

  assign fetch_req_o = (state_q == ST_FETCH);
  assign fetch_addr_o = loc_q;
  assign busy_o = (state_q != ST_IDLE);
  assign done_o = done_q;
  assign operand_location_o = loc_q;
  assign loc_valid_o = lv_q;
  assign program_space_o = ps_q;
  assign data_reg_indirect_o = dri_q;
  assign imm_data_o = imm_q;
  assign imm_valid_o = iv_q;
  assign ext_words_o = words_q;
  assign write_refused_o = wr_q;
  assign bad_mode_o = bad_q;
endmodule : pcea_gen

// ### core/pcea_idx_if.sv
// index operand request and scaled result between top and index unit
interface pcea_idx_if;
  logic [15:0] ext_word;
  logic [31:0] reg_value;
  logic [31:0] scaled;
  logic is_data;
  modport unit (input ext_word, input reg_value, output scaled,
                output is_data);
  modport user (output ext_word, output reg_value, input scaled,
                input is_data);
endinterface : pcea_idx_if

// ### core/pcea_index.sv
// sizes, sign-extends and scales the index register operand
module pcea_index (
  pcea_idx_if.unit idx
);
  import pcea_pkg::*;
  wire long_size = idx.ext_word[XW_WL];
  wire [1:0] scale = idx.ext_word[XW_SC_HI:XW_SC_LO];
  wire [31:0] sized = long_size ? idx.reg_value
                                : sx16(idx.reg_value[15:0]);
  assign idx.scaled = sized << scale;
  assign idx.is_data = ~idx.ext_word[XW_DA];
endmodule : pcea_index

// ### core/pcea_pkg.sv
// shared constants and types for the pc-relative operand location generator
package pcea_pkg;
  localparam logic [2:0] MODE_EXT = 3'h7;
  localparam logic [2:0] REG_ABS_W = 3'h0;
  localparam logic [2:0] REG_ABS_L = 3'h1;
  localparam logic [2:0] REG_PC_DISP = 3'h2;
  localparam logic [2:0] REG_PC_IDX = 3'h3;
  localparam logic [2:0] REG_IMM = 3'h4;
  localparam int EXT_MAX = 6;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [95:0] IMM_RST = 96'h0;
  // extension word field positions (full and brief format)
  localparam int XW_DA = 15;
  localparam int XW_REG_HI = 14;
  localparam int XW_REG_LO = 12;
  localparam int XW_WL = 11;
  localparam int XW_SC_HI = 10;
  localparam int XW_SC_LO = 9;
  localparam int XW_FULL = 8;
  localparam int XW_BS = 7;
  localparam int XW_IS = 6;
  localparam int XW_BASE_HI = 5;
  localparam int XW_BASE_LO = 4;
  localparam int XW_IIS_HI = 2;
  localparam int XW_IIS_LO = 0;
  // displacement size codes
  localparam logic [1:0] DSZ_NULL = 2'h1;
  localparam logic [1:0] DSZ_WORD = 2'h2;
  localparam logic [1:0] DSZ_LONG = 2'h3;

  typedef enum logic [2:0] {
    IMM_BYTE = 3'h0,
    IMM_WORD = 3'h1,
    IMM_LONG = 3'h2,
    IMM_SGL = 3'h3,
    IMM_DBL = 3'h4,
    IMM_EXT = 3'h5,
    IMM_PKD = 3'h6
  } pcea_imm_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CALC = 3'b001,
    ST_FETCH = 3'b011,
    ST_DONE = 3'b010
  } pcea_state_t;

  function automatic logic [31:0] sx16(input logic [15:0] w);
    sx16 = {{16{w[15]}}, w};
  endfunction : sx16

  function automatic logic [31:0] sx8(input logic [7:0] b);
    sx8 = {{24{b[7]}}, b};
  endfunction : sx8

  // displacement from extension words by size code; null gives zero
  function automatic logic [31:0] disp(input logic [1:0] sz,
                                       input logic [15:0] w0,
                                       input logic [15:0] w1);
    case (sz)
      DSZ_WORD: disp = sx16(w0);
      DSZ_LONG: disp = {w0, w1};
      default: disp = 32'h0000_0000;
    endcase
  endfunction : disp

  function automatic logic [2:0] imm_words(input pcea_imm_t t);
    case (t)
      IMM_BYTE, IMM_WORD: imm_words = 3'h1;
      IMM_LONG, IMM_SGL: imm_words = 3'h2;
      IMM_DBL: imm_words = 3'h4;
      default: imm_words = 3'h6;
    endcase
  endfunction : imm_words
endpackage : pcea_pkg

// ### test/pcea_fetch_mem.sv
// operand memory stand-in answering long-word fetches
module pcea_fetch_mem (
  input wire logic ref_clk_i,
  input wire logic slow_i,
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  output logic ack_o = 1'b0,
  output logic [31:0] data_o = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // idle data flips every cycle so an early sample cannot pass
  always @(posedge ref_clk_i) begin
    #5;
    ack_o = 1'b0;
    data_o = ~data_o;
    cnt = req_i ? cnt + 1 : 0;
    if (req_i && cnt > (slow_i ? 5 : 1)) begin
      ack_o = 1'b1;
      data_o = addr_i ^ 32'hC3A5_5A3C;
    end
  end
endmodule : pcea_fetch_mem

// ### test/pcea_gen_props.sv
// port-level timing and address checks for the generator
module pcea_gen_props (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // request
  input wire logic req_i,
  input wire logic [2:0] mode_i,
  input wire logic [2:0] reg_i,
  input wire logic write_i,
  input wire logic [31:0] ext_pc_i,
  input wire logic [15:0] ext_w0_i,
  // fetch and result
  input wire logic fetch_req_o,
  input wire logic [31:0] fetch_addr_o,
  input wire logic fetch_ack_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [31:0] operand_location_o,
  input wire logic loc_valid_o,
  input wire logic program_space_o,
  input wire logic write_refused_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  wire logic take = req_i && !busy_o;
  wire logic rd7 = mode_i == 3'h7 && !write_i;
  wire logic [31:0] w0_sx = {{16{ext_w0_i[15]}}, ext_w0_i};
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  start_busy_a: assert property (take |=> busy_o)
    else $error("busy missing after request");
  quick_done_a: assert property (take && mode_i == 3'h7 && reg_i != 3'h3
    |-> ##3 done_o) else $error("done late");
  busy_end_a: assert property (done_o |-> !busy_o && $past(busy_o))
    else $error("busy wrong around done");
  fetch_hold_a: assert property (fetch_req_o && !fetch_ack_i
    |=> fetch_req_o && $stable(fetch_addr_o)) else $error("fetch dropped");
  fetch_done_a: assert property (fetch_req_o && fetch_ack_i
    |-> ##2 done_o) else $error("done late after fetch");
  refuse_pc_a: assert property (done_o && mode_i == 3'h7 && write_i
    && reg_i inside {3'h2, 3'h3, 3'h4} |-> write_refused_o && !loc_valid_o)
    else $error("pc write accepted");
  pc_disp_a: assert property (done_o && rd7 && reg_i == 3'h2
    |-> operand_location_o == ext_pc_i + w0_sx && program_space_o)
    else $error("pc displacement address wrong");
  abs_short_a: assert property (done_o && rd7 && reg_i == 3'h0
    |-> operand_location_o == w0_sx) else $error("short address wrong");
endmodule : pcea_gen_props

bind pcea_gen pcea_gen_props i_props (.ref_clk_i, .srst_i, .req_i, .mode_i,
  .reg_i, .write_i, .ext_pc_i, .ext_w0_i, .fetch_req_o, .fetch_addr_o,
  .fetch_ack_i, .busy_o, .done_o, .operand_location_o, .loc_valid_o,
  .program_space_o, .write_refused_o);

// ### test/pcea_gen_test.sv
// self-checking bench for the operand location generator
module pcea_gen_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pcea_pkg::*;
  logic ref_clk_i = 0, srst_i = 1, req_i = 0, write_i = 0, slow = 0;
  logic [2:0] mode_i = 0, reg_i = 0, ext_words_o;
  pcea_imm_t imm_type_i = IMM_BYTE;
  logic [31:0] ext_pc_i = 0, index_register_i = 0, fetch_addr_o;
  logic [31:0] fetch_data_i, operand_location_o, e_loc;
  logic [15:0] w [6] = '{default: 16'h0};
  logic fetch_req_o, fetch_ack_i, busy_o, done_o, loc_valid_o, imm_valid_o;
  logic program_space_o, data_reg_indirect_o, write_refused_o, bad_mode_o;
  logic [95:0] imm_data_o;
  int miscompares = 0, compares = 0, n;
  int wc [7] = '{1, 1, 2, 2, 4, 6, 6};
  pcea_gen i_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .req_i(req_i),
    .mode_i(mode_i), .reg_i(reg_i), .write_i(write_i),
    .imm_type_i(imm_type_i), .ext_pc_i(ext_pc_i), .ext_w0_i(w[0]),
    .ext_w1_i(w[1]), .ext_w2_i(w[2]), .ext_w3_i(w[3]), .ext_w4_i(w[4]),
    .ext_w5_i(w[5]), .index_register_i(index_register_i),
    .fetch_req_o(fetch_req_o), .fetch_addr_o(fetch_addr_o),
    .fetch_ack_i(fetch_ack_i), .fetch_data_i(fetch_data_i),
    .busy_o(busy_o), .done_o(done_o),
    .operand_location_o(operand_location_o), .loc_valid_o(loc_valid_o),
    .program_space_o(program_space_o),
    .data_reg_indirect_o(data_reg_indirect_o), .imm_data_o(imm_data_o),
    .imm_valid_o(imm_valid_o), .ext_words_o(ext_words_o),
    .write_refused_o(write_refused_o), .bad_mode_o(bad_mode_o));
  pcea_fetch_mem i_mem (.ref_clk_i, .slow_i(slow), .req_i(fetch_req_o),
    .addr_i(fetch_addr_o), .ack_o(fetch_ack_i), .data_o(fetch_data_i));
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(string s, logic [95:0] e, logic [95:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  function automatic logic [31:0] sx(logic [15:0] x);
    return {{16{x[15]}}, x};
  endfunction : sx
  function automatic logic [31:0] dsp(logic [1:0] s);
    dsp = s == 2'h2 ? sx(w[n]) : s == 2'h3 ? {w[n], w[n + 1]} : 32'h0;
    n += (s == 2'h2) + 2 * (s == 2'h3);
  endfunction : dsp
  function automatic logic [31:0] ix();
    logic [31:0] v;
    v = w[0][11] ? index_register_i : sx(index_register_i[15:0]);
    return v << w[0][10:9];
  endfunction : ix
  function automatic logic [31:0] idx_loc();
    logic [31:0] a, b, x, o;
    if (!w[0][8]) return ext_pc_i + {{24{w[0][7]}}, w[0][7:0]} + ix();
    a = w[0][7] ? 32'h0 : ext_pc_i;
    b = dsp(w[0][5:4]);
    x = w[0][6] ? 32'h0 : ix();
    o = dsp(w[0][1:0]);
    if (w[0][1:0] == 2'h0) return a + b + x;
    a = w[0][2] ? a + b : a + b + x;
    return (a ^ 32'hC3A5_5A3C) + (w[0][2] ? x : 32'h0) + o;
  endfunction : idx_loc
  function automatic logic [95:0] e_imm();
    logic [95:0] e;
    e = 96'h0;
    n = wc[imm_type_i];
    for (int i = 0; i < n; i++) e = {e[79:0], w[i]};
    return imm_type_i == IMM_BYTE ? {88'h0, e[7:0]} : e;
  endfunction : e_imm
  // entered at 5 ns after an edge with the generator idle
  task automatic run(logic [2:0] m, logic [2:0] r, logic wr);
    int t;
    logic rsv, dri;
    mode_i = m;
    reg_i = r;
    write_i = wr;
    req_i = 1;
    @(posedge ref_clk_i) #5;
    req_i = 0;
    t = 0;
    while (done_o !== 1'b1 && t < 60) begin
      @(posedge ref_clk_i) #5;
      t++;
    end
    chk("done", 1, done_o);
    n = 1 + (r == 3'h1);
    e_loc = r == 3'h0 ? sx(w[0]) : r == 3'h1 ? {w[0], w[1]} : 32'h0;
    if (r == 3'h2) e_loc = ext_pc_i + sx(w[0]);
    if (r == 3'h3) e_loc = idx_loc();
    rsv = m != 3'h7 || r > 3'h4 || (r == 3'h3 && !wr && w[0][8] &&
      (w[0][2:0] == 3'h4 || (w[0][6] && w[0][2])));
    dri = w[0][8] && w[0][7] && w[0][5:4] < 2 && !w[0][6] && !w[0][15] &&
      w[0][2:0] == 3'h0;
    if (rsv) chk("bad", 1, bad_mode_o);
    else if (wr) begin
      chk("refused", 1, write_refused_o);
      chk("no_loc", 0, loc_valid_o);
    end else if (r == 3'h4) begin
      chk("imm", e_imm(), imm_data_o);
      chk("imm_n", n, ext_words_o);
      chk("imm_v", 1, imm_valid_o);
    end else begin
      chk("loc", e_loc, operand_location_o);
      chk("loc_v", 1, loc_valid_o);
      chk("words", n, ext_words_o);
      if (r > 3'h1) chk("pspace", 1, program_space_o);
      if (r == 3'h3) chk("dri", dri, data_reg_indirect_o);
    end
    @(posedge ref_clk_i) #5;
  endtask : run
  initial begin
    void'($urandom(32'hA650));
    repeat (2) @(posedge ref_clk_i);
    #5;
    srst_i = 0;
    for (int k = 0; k < 150; k++) begin
      ext_pc_i = $urandom;
      index_register_i = $urandom;
      foreach (w[i]) w[i] = 16'($urandom);
      imm_type_i = pcea_imm_t'(k % 7);
      slow = k[2];
      // keep full-format words legal; reserved codes are not the aim here
      if (w[0][8]) begin
        w[0][3] = 1'b0;
        if (w[0][5:4] == 2'h0) w[0][4] = 1'b1;
        if (w[0][6] || w[0][2:0] == 3'h4) w[0][2] = 1'b0;
      end
      run(3'h7, 3'(k % 5), k % 5 > 1 && k % 9 == 0);
    end
    // reserved memory-indirect code and an unused register field
    w[0] = 16'h0114;
    run(3'h7, 3'h3, 1'b0);
    run(3'h7, 3'h6, 1'b0);
    srst_i = 1;
    @(posedge ref_clk_i) #5;
    chk("reset", 0, {busy_o, done_o, loc_valid_o, imm_valid_o,
      program_space_o, write_refused_o, bad_mode_o, fetch_req_o,
      operand_location_o, ext_words_o});
    srst_i = 0;
    run(3'h5, 3'h2, 1'b0);
    results();
  end
  // about 10 cycles per run at most, with wide margin
  initial begin
    #400000;
    miscompares++;
    results();
  end
endmodule : pcea_gen_test
